// File: design/rsm_pkg.sv
// Constants and state types of the readback upset monitor
package rsm_pkg;

  localparam int RSM_CLK_PER_NS = 40;
  localparam int RSM_LINK_PER_NS = 32;
  localparam int RSM_RB_FMIN_KHZ = 1000;
  localparam int RSM_RB_FMAX_KHZ = 2000;
  localparam int RSM_RB_MINPER_NS = 1000000 / RSM_RB_FMAX_KHZ;
  localparam int RSM_DIV =
    (RSM_RB_MINPER_NS + RSM_LINK_PER_NS - 1) / RSM_LINK_PER_NS;
  localparam int RSM_DIV_W = $clog2(RSM_DIV);
  localparam int RSM_RECONF_NS = 300;
  localparam int RSM_RECONF_CYC =
    (RSM_RECONF_NS + RSM_CLK_PER_NS - 1) / RSM_CLK_PER_NS;
  localparam int RSM_RC_W = 4;
  localparam int RSM_CRC_W = 11;
  localparam int RSM_CNT_W = 20;
  localparam int RSM_WD_W = 32;
  localparam int RSM_CRC_POS_DEF = 1000;
  localparam int RSM_MAX_BITS_DEF = 1000000;
  localparam int RSM_WD_TERM_DEF = 1000000;
  localparam logic [5:0] RSM_PREAMBLE = 6'h3E;

  typedef enum logic [4:0] {
    RSM_L_IDLE = 5'h01,
    RSM_L_PRE = 5'h02,
    RSM_L_CNT = 5'h04,
    RSM_L_ZERO = 5'h08,
    RSM_L_CRC = 5'h10
  } rsm_lst_e;

  typedef enum logic [2:0] {
    RSM_PH_INIT = 3'h1,
    RSM_PH_REF = 3'h2,
    RSM_PH_CMP = 3'h4
  } rsm_ph_e;

  typedef struct packed {
    logic rst_m, rst_s, st_m, st_s, st_p, d_m, d_s;
    rsm_lst_e st;
    logic [RSM_DIV_W-1:0] div;
    logic [RSM_CNT_W-1:0] cnt, bits;
    logic [5:0] shift;
    logic trig, clk, done_tgl, err;
    logic [RSM_CRC_W-1:0] crc;
  } rsm_lnk_s;

  localparam rsm_lnk_s RSM_LNK_RST = '{rst_m: 1'b0, rst_s: 1'b0,
    st_m: 1'b0, st_s: 1'b0, st_p: 1'b0, d_m: 1'b0, d_s: 1'b0,
    st: RSM_L_IDLE, div: '0, cnt: '0, bits: '0, shift: 6'h00,
    trig: 1'b0, clk: 1'b0, done_tgl: 1'b0, err: 1'b0, crc: '0};

  typedef struct packed {
    logic dn_m, dn_s, cl_m, cl_s, cl_p, dt_m, dt_s, dt_p;
    logic start_tgl, busy, ref_valid, upset, armed, rc_n, global_set_reset;
    rsm_ph_e phase;
    logic [RSM_CRC_W-1:0] tmr0, tmr1, tmr2;
    logic [RSM_RC_W-1:0] rc_cnt;
    logic [RSM_WD_W-1:0] wd_cnt;
  } rsm_mon_s;

  localparam rsm_mon_s RSM_MON_RST = '{dn_m: 1'b1, dn_s: 1'b1,
    cl_m: 1'b1, cl_s: 1'b1, cl_p: 1'b1, dt_m: 1'b0, dt_s: 1'b0,
    dt_p: 1'b0, start_tgl: 1'b0, busy: 1'b0, ref_valid: 1'b0,
    upset: 1'b0, armed: 1'b1, rc_n: 1'b1, global_set_reset: 1'b0,
    phase: RSM_PH_INIT, tmr0: '0, tmr1: '0, tmr2: '0, rc_cnt: '0,
    wd_cnt: '0};

endpackage : rsm_pkg

// File: design/rsm_link.sv
// Link-clock side: readback clock, trigger, preamble search, checksum
`timescale 1ns/10ps
module rsm_link
  import rsm_pkg::*;
#(
  parameter int CRC_POS = RSM_CRC_POS_DEF,
  parameter int MAX_BITS = RSM_MAX_BITS_DEF
)
(
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic start_tgl,
  input wire logic rb_data,
  output logic rb_trig,
  output logic rb_clk,
  output logic done_tgl,
  output logic [RSM_CRC_W-1:0] crc,
  output logic err
);

  rsm_lnk_s s;
  rsm_lnk_s n;
  logic tick;
  logic fin;
  logic [5:0] sh;

  always_comb
  begin
    n = s;
    fin = 1'b0;
    tick = (s.div == RSM_DIV_W'(RSM_DIV - 1));
    sh = {s.shift[4:0], s.d_s};
    if (!s.rst_s)
    begin
      n = RSM_LNK_RST;
    end
    else
    begin
      if (s.trig)
      begin
        // Free-running divider while the trigger stands
        n.div = tick ? '0 : s.div + 1'b1;
        n.clk = (n.div < RSM_DIV_W'(RSM_DIV / 2));
      end
      case (s.st)
        RSM_L_IDLE:
        begin
          if (s.st_s != s.st_p)
          begin
            n.trig = 1'b1;
            n.clk = 1'b1;
            n.div = '0;
            n.bits = '0;
            n.shift = 6'h00;
            n.err = 1'b0;
            n.st = RSM_L_PRE;
          end
        end
        RSM_L_PRE:
        begin
          if (tick)
          begin
            n.shift = sh;
            n.cnt = '0;
            if (sh == RSM_PREAMBLE)
            begin
              n.st = RSM_L_CNT;
            end
          end
        end
        RSM_L_CNT:
        begin
          if (tick)
          begin
            if (s.cnt == RSM_CNT_W'(CRC_POS - 1))
            begin
              n.st = RSM_L_ZERO;
            end
            else
            begin
              n.cnt = s.cnt + 1'b1;
            end
          end
        end
        RSM_L_ZERO:
        begin
          if (tick)
          begin
            n.err = s.d_s;
            n.cnt = '0;
            n.st = RSM_L_CRC;
          end
        end
        RSM_L_CRC:
        begin
          if (tick)
          begin
            n.crc = {s.crc[RSM_CRC_W-2:0], s.d_s};
            n.cnt = s.cnt + 1'b1;
            fin = (s.cnt == RSM_CNT_W'(RSM_CRC_W - 1));
          end
        end
        default:
        begin
          n.st = RSM_L_IDLE;
        end
      endcase
      if (tick && s.st != RSM_L_IDLE && !fin)
      begin
        n.bits = s.bits + 1'b1;
        if (s.bits == RSM_CNT_W'(MAX_BITS - 1))
        begin
          fin = 1'b1;
          n.err = 1'b1;
        end
      end
      if (fin)
      begin
        // Trigger drops once the checksum is through or the bit limit is reached
        n.trig = 1'b0;
        n.clk = 1'b0;
        n.done_tgl = ~s.done_tgl;
        n.st = RSM_L_IDLE;
      end
    end
    n.rst_m = rst_n;
    n.rst_s = s.rst_m;
    n.st_m = start_tgl;
    n.st_s = s.st_m;
    n.st_p = s.st_s;
    n.d_m = rb_data;
    n.d_s = s.d_m;
  end

  always_ff @(posedge link_clk)
  begin
    s <= n;
  end

  assign rb_trig = s.trig;
  assign rb_clk = s.clk;
  assign done_tgl = s.done_tgl;
  assign crc = s.crc;
  assign err = s.err;

  property p_trig_end;
    @(posedge link_clk) disable iff (!s.rst_s)
    $fell(rb_trig) |-> $changed(done_tgl);
  endproperty
  a_trig_end: assert property (p_trig_end)
    else $error("trigger released before readback end");

  property p_clk_high;
    @(posedge link_clk) disable iff (!s.rst_s)
    $rose(rb_clk) |-> rb_clk[*8] ##1 !rb_clk;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("readback clock high phase wrong");

  property p_clk_low;
    @(posedge link_clk) disable iff (!s.rst_s)
    ($fell(rb_clk) && rb_trig) |-> !rb_clk[*8] ##1 (rb_clk || !rb_trig);
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("readback clock gap");

  property p_preamble;
    @(posedge link_clk) disable iff (!s.rst_s)
    (s.st == RSM_L_PRE && tick && sh == RSM_PREAMBLE && !fin)
      |=> s.st == RSM_L_CNT;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("preamble not taken");

endmodule : rsm_link

// File: design/rsm_monitor.sv
// Top of the readback upset monitor with voting and watchdog
`timescale 1ns/10ps
module rsm_monitor
  import rsm_pkg::*;
#(
  parameter int CRC_POS = RSM_CRC_POS_DEF,
  parameter int MAX_BITS = RSM_MAX_BITS_DEF,
  parameter int WD_TERM = RSM_WD_TERM_DEF,
  parameter int N_OUT = 8
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LINK_CLK,
  input wire logic READBACK_DATA,
  input wire logic NB_DONE,
  input wire logic NB_CONST_LOW,
  input wire logic GSR_IN,
  input wire logic [N_OUT-1:0] MAIN_OUT,
  input wire logic [N_OUT-1:0] DUP_OUT,
  output logic READBACK_TRIGGER,
  output logic READBACK_CLOCK,
  output logic RECONFIG_N,
  output logic GLOBAL_SET_RESET,
  output logic GLOBAL_OUTPUT_TRISTATE,
  output logic [N_OUT-1:0] USER_OUT,
  output logic [N_OUT-1:0] USER_OE_N,
  output logic UPSET,
  output logic REF_VALID
);

  localparam logic [RSM_WD_W-1:0] WD_LAST = RSM_WD_W'(WD_TERM - 1);

  function automatic logic [RSM_CRC_W-1:0] vote(
    input logic [RSM_CRC_W-1:0] a,
    input logic [RSM_CRC_W-1:0] b,
    input logic [RSM_CRC_W-1:0] c
  );
    vote = (a & b) | (a & c) | (b & c);
  endfunction : vote

  rsm_mon_s s;
  rsm_mon_s n;
  logic lk_done;
  logic lk_err;
  logic [RSM_CRC_W-1:0] lk_crc;
  logic ev;
  logic online;
  logic fire_rc;
  logic wd_fire;
  logic global_output_tristate;
  logic [RSM_CRC_W-1:0] ref_crc;

  // ------------------------------------------------------------
  // Readback engine on the link clock
  // ------------------------------------------------------------
  rsm_link #(
    .CRC_POS(CRC_POS),
    .MAX_BITS(MAX_BITS)
  ) u_link (
    .link_clk(LINK_CLK),
    .rst_n(RST_N),
    .start_tgl(s.start_tgl),
    .rb_data(READBACK_DATA),
    .rb_trig(READBACK_TRIGGER),
    .rb_clk(READBACK_CLOCK),
    .done_tgl(lk_done),
    .crc(lk_crc),
    .err(lk_err)
  );

  // ------------------------------------------------------------
  // Sequencer, reference store, reconfiguration and watchdog
  // ------------------------------------------------------------
  always_comb
  begin
    n = s;
    fire_rc = 1'b0;
    wd_fire = 1'b0;
    // Checksum word is stable once the done toggle is seen
    ev = (s.dt_s != s.dt_p);
    online = s.dn_s && !s.cl_s;
    ref_crc = vote(s.tmr0, s.tmr1, s.tmr2);
    n.dn_m = NB_DONE;
    n.dn_s = s.dn_m;
    n.cl_m = NB_CONST_LOW;
    n.cl_s = s.cl_m;
    n.cl_p = s.cl_s;
    n.dt_m = lk_done;
    n.dt_s = s.dt_m;
    n.dt_p = s.dt_s;
    n.upset = 1'b0;
    if (s.cl_s)
    begin
      if (s.wd_cnt == WD_LAST)
      begin
        wd_fire = 1'b1;
        n.wd_cnt = '0;
      end
      else
      begin
        n.wd_cnt = s.wd_cnt + 1'b1;
      end
    end
    else
    begin
      n.wd_cnt = '0;
    end
    // Neighbour back online or watchdog expiry resets both sides
    n.global_set_reset = wd_fire || (s.cl_p && !s.cl_s);
    if (ev)
    begin
      n.busy = 1'b0;
      case (s.phase)
        RSM_PH_INIT:
        begin
          n.phase = RSM_PH_REF;
        end
        RSM_PH_REF:
        begin
          if (!lk_err)
          begin
            n.tmr0 = lk_crc;
            n.tmr1 = lk_crc;
            n.tmr2 = lk_crc;
            n.ref_valid = 1'b1;
            n.phase = RSM_PH_CMP;
          end
        end
        RSM_PH_CMP:
        begin
          if (!lk_err && ref_crc != lk_crc)
          begin
            n.upset = 1'b1;
            fire_rc = 1'b1;
          end
        end
        default:
        begin
          n.phase = RSM_PH_INIT;
        end
      endcase
    end
    if (s.dn_s)
    begin
      n.armed = 1'b1;
    end
    else if (s.armed)
    begin
      fire_rc = 1'b1;
    end
    if (wd_fire)
    begin
      fire_rc = 1'b1;
    end
    if (fire_rc && s.rc_cnt == '0)
    begin
      n.rc_cnt = RSM_RC_W'(RSM_RECONF_CYC);
      n.rc_n = 1'b0;
      n.armed = 1'b0;
    end
    else if (s.rc_cnt != '0)
    begin
      n.rc_cnt = s.rc_cnt - 1'b1;
      n.rc_n = (s.rc_cnt == RSM_RC_W'(1));
    end
    // Any reconfiguration of the neighbour starts over
    if (fire_rc || !online)
    begin
      n.phase = RSM_PH_INIT;
      n.ref_valid = 1'b0;
    end
    if (!s.busy && !ev && online && s.rc_cnt == '0)
    begin
      n.start_tgl = ~s.start_tgl;
      n.busy = 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      s <= RSM_MON_RST;
    end
    else
    begin
      s <= n;
    end
  end

  // ------------------------------------------------------------
  // Hard-wired pair comparison and tristate path
  // ------------------------------------------------------------
  assign global_output_tristate = (|(MAIN_OUT ^ DUP_OUT)) | s.global_set_reset | GSR_IN;
  assign GLOBAL_OUTPUT_TRISTATE = global_output_tristate;
  assign USER_OUT = MAIN_OUT;
  assign USER_OE_N = {N_OUT{global_output_tristate}};
  assign GLOBAL_SET_RESET = s.global_set_reset;
  assign RECONFIG_N = s.rc_n;
  assign UPSET = s.upset;
  assign REF_VALID = s.ref_valid;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_discard;
    @(posedge CLK) disable iff (!RST_N)
    (ev && s.phase == RSM_PH_INIT && online && !fire_rc)
      |=> (s.phase == RSM_PH_REF && !s.upset && $stable(s.tmr0));
  endproperty
  a_discard: assert property (p_discard)
    else $error("first readback not discarded");

  property p_ref;
    @(posedge CLK) disable iff (!RST_N)
    (ev && s.phase == RSM_PH_REF && !lk_err)
      |=> (s.tmr0 == $past(lk_crc) && s.tmr1 == s.tmr0
           && s.tmr2 == s.tmr0);
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference not stored in all copies");

  property p_cmp;
    @(posedge CLK) disable iff (!RST_N)
    (ev && s.phase == RSM_PH_CMP && !lk_err && ref_crc != lk_crc)
      |=> s.upset;
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("checksum mismatch not flagged");

  property p_no_false;
    @(posedge CLK) disable iff (!RST_N)
    (ev && s.phase == RSM_PH_CMP && ref_crc == lk_crc) |=> !s.upset;
  endproperty
  a_no_false: assert property (p_no_false)
    else $error("upset flagged on matching checksum");

  property p_rc_len;
    @(posedge CLK) disable iff (!RST_N)
    $fell(RECONFIG_N) |-> !RECONFIG_N[*8] ##1 RECONFIG_N;
  endproperty
  a_rc_len: assert property (p_rc_len)
    else $error("reconfiguration pulse length wrong");

  property p_restart;
    @(posedge CLK) disable iff (!RST_N)
    !online |=> (s.phase == RSM_PH_INIT && !REF_VALID);
  endproperty
  a_restart: assert property (p_restart)
    else $error("sequence not restarted");

  property p_wd_inc;
    @(posedge CLK) disable iff (!RST_N)
    (s.cl_s && s.wd_cnt != WD_LAST)
      |=> s.wd_cnt == $past(s.wd_cnt) + 1'b1;
  endproperty
  a_wd_inc: assert property (p_wd_inc)
    else $error("watchdog did not count");

  property p_wd_fire;
    @(posedge CLK) disable iff (!RST_N)
    (s.cl_s && s.wd_cnt == WD_LAST) |=> (GLOBAL_SET_RESET && s.wd_cnt == '0);
  endproperty
  a_wd_fire: assert property (p_wd_fire)
    else $error("watchdog expiry without global reset");

  property p_online;
    @(posedge CLK) disable iff (!RST_N)
    $fell(s.cl_s) |-> ##1 GLOBAL_SET_RESET;
  endproperty
  a_online: assert property (p_online)
    else $error("no global reset on return online");

  property p_gts;
    @(posedge CLK) disable iff (!RST_N)
    (|(MAIN_OUT ^ DUP_OUT) || GLOBAL_SET_RESET)
      |-> (GLOBAL_OUTPUT_TRISTATE && &USER_OE_N);
  endproperty
  a_gts: assert property (p_gts)
    else $error("outputs not tristated on disagreement");

endmodule : rsm_monitor

// File: testbench/rsm_nb_model.sv
// Neighbour readback port model: answers a trigger with a serial stream
`timescale 1ns/10ps
module rsm_nb_model
  import rsm_pkg::*;
#(
  parameter int CRC_POS = 20
)
(
  input wire logic rb_trig,
  input wire logic rb_clk,
  input wire logic [RSM_CRC_W-1:0] crc,
  input wire logic bad_zero,
  output logic rb_data,
  output int viol
);
  // Filler holds a near-preamble run of four ones
  localparam logic [7:0] FILL = 8'h7A;
  bit q[$];
  realtime t_rise;

  initial
  begin
    rb_data = 1'b0;
    viol = 0;
    t_rise = 0;
  end

  // ----------------------------------------------------------------
  // Stream build and shift-out
  // ----------------------------------------------------------------
  always @(posedge rb_trig)
  begin
    q = {};
    for (int i = 7; i >= 0; i--)
      q.push_back(FILL[i]);
    for (int i = 5; i >= 0; i--)
      q.push_back(RSM_PREAMBLE[i]);
    for (int i = 0; i <= CRC_POS; i++)
      q.push_back((i == CRC_POS) ? bad_zero : 1'b0);
    for (int i = RSM_CRC_W - 1; i >= 0; i--)
      q.push_back(crc[i]);
    rb_data = q.pop_front();
  end

  always @(negedge rb_clk)
    if (rb_trig)
      rb_data = (q.size() > 0) ? q.pop_front() : ~rb_data;

  // Released line has no pull, so it wanders
  always #48
    if (!rb_trig)
      rb_data = ~rb_data;

  // ----------------------------------------------------------------
  // Link checks on the monitor's side
  // ----------------------------------------------------------------
  always @(posedge rb_clk)
  begin
    if (rb_trig && t_rise > 0 &&
        ($realtime - t_rise < 500 || $realtime - t_rise > 1000))
      viol++;
    t_rise = $realtime;
  end

  always @(negedge rb_trig)
  begin
    if (q.size() > 0)
      viol++;
    t_rise = 0;
  end
endmodule : rsm_nb_model

// File: testbench/rsm_monitor_tb.sv
// Self-checking bench of the readback upset monitor
`timescale 1ns/10ps
module rsm_monitor_tb;
  import rsm_pkg::*;
  localparam int WD = 50;
  logic clk, rst_n, link_clk, rb_data, nb_done, nb_const_low, gsr_in;
  logic [7:0] main_out, dup_out, user_out, user_oe_n;
  logic rb_trig, rb_clk, reconfig_n, global_set_reset, global_output_tristate, upset, ref_valid;
  logic [RSM_CRC_W-1:0] crc_val;
  logic bad_zero;
  int viol, failures, comparisons, rbs, ups, gsrs, pulses, run, last;

  rsm_monitor #(.CRC_POS(20), .MAX_BITS(200), .WD_TERM(WD), .N_OUT(8))
  rsm_monitor_inst (.CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk),
    .READBACK_DATA(rb_data), .NB_DONE(nb_done),
    .NB_CONST_LOW(nb_const_low), .GSR_IN(gsr_in), .MAIN_OUT(main_out),
    .DUP_OUT(dup_out), .READBACK_TRIGGER(rb_trig),
    .READBACK_CLOCK(rb_clk), .RECONFIG_N(reconfig_n),
    .GLOBAL_SET_RESET(global_set_reset), .GLOBAL_OUTPUT_TRISTATE(global_output_tristate),
    .USER_OUT(user_out), .USER_OE_N(user_oe_n), .UPSET(upset),
    .REF_VALID(ref_valid));

  rsm_nb_model #(.CRC_POS(20)) rsm_nb_model_inst (.rb_trig(rb_trig),
    .rb_clk(rb_clk), .crc(crc_val), .bad_zero(bad_zero), .rb_data(rb_data),
    .viol(viol));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  // ----------------------------------------------------------------
  // Event monitors
  // ----------------------------------------------------------------
  always @(negedge rb_trig)
    rbs++;

  always @(posedge clk)
  begin
    if (upset === 1'b1)
      ups++;
    if (global_set_reset === 1'b1)
      gsrs++;
    if (reconfig_n === 1'b0)
      run++;
    else if (run != 0)
    begin
      last = run;
      run = 0;
      pulses++;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic wait_rb();
    int n0;
    int k;
    n0 = rbs;
    k = 0;
    while (rbs == n0 && k < 2000)
    begin
      @(posedge clk);
      k++;
    end
    #1;
    check("readback end", 1, k < 2000);
  endtask : wait_rb

  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_seq(input logic [10:0] first, refv, after);
    int u0;
    u0 = ups;
    crc_val = first;
    wait_rb();
    crc_val = refv;
    step(8);
    check("ref_valid after first", 0, ref_valid);
    wait_rb();
    step(8);
    check("ref_valid after second", 1, ref_valid);
    wait_rb();
    crc_val = after;
    step(10);
    check("upset after third", u0, ups);
  endtask : t_seq

  task automatic t_mismatch();
    int u0;
    int p0;
    u0 = ups;
    p0 = pulses;
    wait_rb();
    crc_val = 11'h3C1;
    step(16);
    check("upset pulses", u0 + 1, ups);
    check("reconfig pulses", p0 + 1, pulses);
    check("reconfig width", 8, last);
    check("ref_valid after upset", 0, ref_valid);
  endtask : t_mismatch

  task automatic t_zero_err();
    int u0;
    u0 = ups;
    wait_rb();
    bad_zero = 1'b1;
    crc_val = 11'h3C1;
    wait_rb();
    bad_zero = 1'b0;
    crc_val = 11'h2B4;
    step(8);
    check("upset on bad zero bit", u0, ups);
    check("ref_valid after bad zero bit", 1, ref_valid);
  endtask : t_zero_err

  task automatic t_done_low();
    int p0;
    int k;
    p0 = pulses;
    k = 0;
    nb_done = 1'b0;
    step(14);
    check("reconfig on done low", p0 + 1, pulses);
    check("reconfig width", 8, last);
    check("ref_valid offline", 0, ref_valid);
    while (rb_trig === 1'b1 && k < 2000)
    begin
      step(1);
      k++;
    end
    nb_done = 1'b1;
  endtask : t_done_low

  task automatic t_gts();
    for (int i = 0; i < 8; i++)
    begin
      main_out = 8'hA5;
      dup_out = 8'hA5 ^ (8'h01 << i);
      #2;
      check("tristate on pair mismatch", 1, global_output_tristate);
      check("outputs released", 8'hFF, user_oe_n);
    end
    dup_out = 8'hA5;
    #2;
    check("tristate idle", 0, global_output_tristate);
    check("outputs driven", 8'h00, user_oe_n);
    check("user data", 8'hA5, user_out);
    gsr_in = 1'b1;
    #2;
    check("tristate on reset in", 1, global_output_tristate);
    gsr_in = 1'b0;
    step(1);
  endtask : t_gts

  task automatic t_watchdog();
    int g0;
    int p0;
    g0 = gsrs;
    p0 = pulses;
    nb_const_low = 1'b1;
    step(WD - 5);
    check("watchdog early", g0, gsrs);
    step(19);
    check("watchdog reset pulse", g0 + 1, gsrs);
    check("watchdog reconfig", p0 + 1, pulses);
    nb_const_low = 1'b0;
    step(6);
    check("online reset pulse", g0 + 2, gsrs);
  endtask : t_watchdog

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    nb_done = 1'b1;
    nb_const_low = 1'b0;
    gsr_in = 1'b0;
    main_out = 8'h00;
    dup_out = 8'h00;
    crc_val = 11'h155;
    bad_zero = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_seq(11'h155, 11'h6A3, 11'h1C2);
    t_mismatch();
    t_seq(11'h3C1, 11'h2B4, 11'h2B4);
    t_zero_err();
    t_done_low();
    t_gts();
    t_watchdog();
    check("partner link rules", 0, viol);
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule : rsm_monitor_tb
